// File: logic/hss_pkg.sv
// Constants and types shared by the high-side switch controller
`default_nettype none
package hss_pkg;
   localparam int CLK_PERIOD_NS        = 20;
   localparam int LATCH_CLEAR_TIME_NS  = 300000;
   localparam int WAKE_TIME_NS         = 100000;
   localparam int SENSE_SETTLE_TIME_NS = 50000;
   localparam int CNT_W                = 20;
   // Least times, rounded up to whole cycles
   localparam int LATCH_CLEAR_CYC  = (LATCH_CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_CYC         = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SENSE_SETTLE_CYC = (SENSE_SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      ST_OFF       = 3'b000,
      ST_SETTLE    = 3'b001,
      ST_ON        = 3'b010,
      ST_ACK       = 3'b011,
      ST_OFF_BLANK = 3'b100
   } hss_state_type;
endpackage
`default_nettype wire

// File: logic/hss_tmr_if.sv
// Carrier between the controller sequencer and its interval timer
`default_nettype none
interface hss_tmr_if;
   import hss_pkg::*;
   logic             start;
   logic [CNT_W-1:0] load;
   logic             done;
   logic             busy;
   modport ctl (output start, output load, input done, input busy);
   modport tmr (input start, input load, output done, output busy);
endinterface
`default_nettype wire

// File: logic/hss_timer.sv
// Down-counting interval timer with a one-cycle done pulse
`default_nettype none
module hss_timer (
   input wire logic clk,
   input wire logic rst_n,
   hss_tmr_if.tmr   tmr
);
   import hss_pkg::*;

   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;
   logic             done_q;
   logic             done_d;

   always_comb begin
      count_d = count_q;
      done_d  = 1'b0;
      if (tmr.start) begin
         count_d = tmr.load; // RQ17
      end else if (count_q != '0) begin
         count_d = count_q - 1'b1;
         done_d  = (count_q == {{(CNT_W-1){1'b0}}, 1'b1});
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_q <= '0;
         done_q  <= 1'b0;
      end else begin
         count_q <= count_d;
         done_q  <= done_d;
      end
   end

   assign tmr.done = done_q;
   assign tmr.busy = (count_q != '0);
endmodule // hss_timer
`default_nettype wire

// File: logic/hss_ctrl.sv
// Host controller that drives the switch command pin and reads the sense fault level
// What the device and this block must do
// RQ1 - Device latches off on over-temperature
// RQ2 - Acknowledge fault by command low long enough
// RQ3 - Device turns off on ground loss
// RQ4 - After ground returns, apply reset through command
// RQ5 - Device follows command between supply limits
// RQ6 - Proportional sense only without hard fault
// RQ7 - Device drives fault current on fault
// RQ8 - Fault indication clears after low past clear time
// RQ9 - Off-state faults show after clear time only
// RQ10 - Ignore sense while stage switches
// RQ11 - Add wake delay when logic slept
// RQ12 - Sense meaning depends on command and low time
// RQ13 - Fault current until command low past clear
// RQ14 - Command high on, low off
// RQ15 - Device latches off on over-current
// RQ16 - Device logic sleeps after clear time low
// RQ17 - Clear and wake times are cycle counts
`default_nettype none
module hss_ctrl #(
   parameter int unsigned CLEAR_CYC = hss_pkg::LATCH_CLEAR_CYC,
   parameter int unsigned WAKE_CYC  = hss_pkg::WAKE_CYC
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic user_on,
   input  wire logic gnd_reset_req,
   input  wire logic sense_fault_pin,
   output logic      switch_cmd,
   output logic      sense_valid,
   output logic      fault_latched,
   output logic      offstate_fault,
   output logic      ack_busy
);
   import hss_pkg::*;

   localparam logic [CNT_W-1:0] SETTLE_LD   = CNT_W'(SENSE_SETTLE_CYC);
   localparam logic [CNT_W-1:0] WAKE_LD     = CNT_W'(WAKE_CYC);
   // One cycle beyond the clear time so the release is strictly past it
   localparam logic [CNT_W-1:0] ACK_LD      = CNT_W'(CLEAR_CYC + 1);
   // Assumed sleep falls CLEAR_CYC cycles after command low, the same cycle as the device's: a needless wake wait is harmless, a missing one is not
   localparam logic [CNT_W-1:0] SLEEP_LD    = CNT_W'(CLEAR_CYC - SENSE_SETTLE_CYC - 2);
   localparam logic [CNT_W-1:0] CNT_MAX     = '1;
   localparam int               CLEAR_INT   = CLEAR_CYC;
   localparam int               SETTLE_INT  = SENSE_SETTLE_CYC;
   localparam int               WAKE_INT    = WAKE_CYC;

   hss_tmr_if tmr_bus ();

   hss_timer u_timer (
      .clk   (clk),
      .rst_n (rst_n),
      .tmr   (tmr_bus)
   );

   // Pin synchroniser; only the second stage is read
   logic fault_meta_q;
   logic fault_s_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fault_meta_q <= 1'b0;
         fault_s_q    <= 1'b0;
      end else begin
         fault_meta_q <= sense_fault_pin;
         fault_s_q    <= fault_meta_q;
      end
   end

   hss_state_type state_q;
   hss_state_type state_d;
   logic          cmd_q;
   logic          cmd_d;
   logic          valid_q;
   logic          valid_d;
   logic          fault_q;
   logic          fault_d;
   logic          offst_q;
   logic          offst_d;
   logic          asleep_q;
   logic          asleep_d;
   logic          woke_q;
   logic          woke_d;
   logic          ack_q;
   logic          ack_d;

   always_comb begin
      state_d       = state_q;
      cmd_d         = cmd_q;
      valid_d       = valid_q;
      fault_d       = fault_q;
      offst_d       = offst_q;
      asleep_d      = asleep_q;
      woke_d        = woke_q;
      tmr_bus.start = 1'b0;
      tmr_bus.load  = '0;
      if (gnd_reset_req && state_q != ST_ACK) begin
         // Forced low pulse to restart the device after a ground fault
         state_d       = ST_ACK; // RQ4
         cmd_d         = 1'b0;
         valid_d       = 1'b0;
         offst_d       = 1'b0;
         tmr_bus.start = 1'b1;
         tmr_bus.load  = ACK_LD;
      end else begin
         case (state_q)
            ST_OFF: begin
               if (tmr_bus.done) begin
                  asleep_d = 1'b1; // RQ16
               end
               // Only after the clear time does the fault level mean an off-state fault
               offst_d = asleep_q && fault_s_q; // RQ9
               if (user_on) begin
                  state_d       = ST_SETTLE;
                  cmd_d         = 1'b1; // RQ14
                  offst_d       = 1'b0;
                  // Sleep timer expiring in this very cycle counts as asleep
                  woke_d        = asleep_q || tmr_bus.done;
                  tmr_bus.start = 1'b1;
                  tmr_bus.load  = (asleep_q || tmr_bus.done) ? SETTLE_LD + WAKE_LD : SETTLE_LD; // RQ11
               end
            end
            ST_SETTLE: begin
               if (!user_on) begin
                  state_d       = ST_OFF_BLANK;
                  cmd_d         = 1'b0;
                  tmr_bus.start = 1'b1;
                  tmr_bus.load  = SETTLE_LD;
               end else if (tmr_bus.done) begin
                  state_d  = ST_ON;
                  valid_d  = 1'b1; // RQ10
                  asleep_d = 1'b0;
               end
            end
            ST_ON: begin
               if (fault_s_q) begin
                  // Device has latched off; sense holds the fault level
                  state_d       = ST_ACK; // RQ1 RQ15 RQ7
                  fault_d       = 1'b1;
                  cmd_d         = 1'b0;
                  valid_d       = 1'b0;
                  tmr_bus.start = 1'b1;
                  tmr_bus.load  = ACK_LD; // RQ2
               end else if (!user_on) begin
                  state_d       = ST_OFF_BLANK;
                  cmd_d         = 1'b0;
                  valid_d       = 1'b0; // RQ10
                  tmr_bus.start = 1'b1;
                  tmr_bus.load  = SETTLE_LD;
               end
            end
            ST_OFF_BLANK: begin
               // Turn-off transient; restart waits so blanking is never cut short
               if (tmr_bus.done) begin
                  state_d       = ST_OFF;
                  tmr_bus.start = 1'b1;
                  tmr_bus.load  = SLEEP_LD;
               end
            end
            ST_ACK: begin
               if (tmr_bus.done) begin
                  state_d  = ST_OFF;
                  fault_d  = 1'b0; // RQ8 RQ13
                  asleep_d = 1'b1;
               end
            end
            default: begin
               state_d = ST_OFF;
               cmd_d   = 1'b0;
               valid_d = 1'b0;
            end
         endcase
      end
      ack_d = (state_d == ST_ACK); // RQ2
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q  <= ST_OFF;
         cmd_q    <= 1'b0;
         valid_q  <= 1'b0;
         fault_q  <= 1'b0;
         offst_q  <= 1'b0;
         asleep_q <= 1'b1;
         woke_q   <= 1'b0;
         ack_q    <= 1'b0;
      end else begin
         state_q  <= state_d;
         cmd_q    <= cmd_d;
         valid_q  <= valid_d;
         fault_q  <= fault_d;
         offst_q  <= offst_d;
         asleep_q <= asleep_d;
         woke_q   <= woke_d;
         ack_q    <= ack_d;
      end
   end

   assign switch_cmd     = cmd_q;
   assign sense_valid    = valid_q;
   assign fault_latched  = fault_q;
   assign offstate_fault = offst_q;
   assign ack_busy       = ack_q;

   // Cycle counters read only by the checks below
   logic [CNT_W-1:0] low_cnt_q;
   logic [CNT_W-1:0] low_cnt_d;
   logic [CNT_W-1:0] on_cnt_q;
   logic [CNT_W-1:0] on_cnt_d;

   always_comb begin
      low_cnt_d = (cmd_q || low_cnt_q == CNT_MAX) ? (cmd_q ? '0 : low_cnt_q) : low_cnt_q + 1'b1;
      on_cnt_d  = (!cmd_q || on_cnt_q == CNT_MAX) ? (cmd_q ? on_cnt_q : '0) : on_cnt_q + 1'b1;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         low_cnt_q <= '0;
         on_cnt_q  <= '0;
      end else begin
         low_cnt_q <= low_cnt_d;
         on_cnt_q  <= on_cnt_d;
      end
   end

   a_fault_clear_time: assert property (@(posedge clk) disable iff (!rst_n) // RQ8
      $fell(fault_q) |-> (int'(low_cnt_q) > CLEAR_INT) && !cmd_q)
      else $error("fault released before command was low past the clear time");

   a_ack_holds_low: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
      (state_q == ST_ACK) |-> !cmd_q && !valid_q)
      else $error("command not held low during acknowledge");

   a_blank_on_rise: assert property (@(posedge clk) disable iff (!rst_n) // RQ10
      $rose(cmd_q) |-> !valid_q [*8])
      else $error("sense marked valid while stage turns on");

   a_blank_on_fall: assert property (@(posedge clk) disable iff (!rst_n) // RQ10
      $fell(cmd_q) |-> !valid_q)
      else $error("sense marked valid while stage turns off");

   a_wake_delay: assert property (@(posedge clk) disable iff (!rst_n) // RQ11
      $rose(valid_q) |-> int'(on_cnt_q) >= (woke_q ? SETTLE_INT + WAKE_INT : SETTLE_INT))
      else $error("sense valid before settle and wake time");

   a_gnd_reset_ack: assert property (@(posedge clk) disable iff (!rst_n) // RQ4
      (gnd_reset_req && state_q != ST_ACK) |=> (state_q == ST_ACK) && !cmd_q)
      else $error("ground reset request did not start a low pulse");

   a_fault_to_ack: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
      (state_q == ST_ON && fault_s_q && !gnd_reset_req) |=> fault_q && !cmd_q ##1 ack_busy)
      else $error("sensed fault not acknowledged");

   a_ack_timer_runs: assert property (@(posedge clk) disable iff (!rst_n) // RQ2
      (state_q == ST_ACK) |-> tmr_bus.busy || tmr_bus.done)
      else $error("acknowledge timer stopped before the low pulse ended");
endmodule // hss_ctrl
`default_nettype wire

// File: verification/hss_dev_model.sv
// Behavioural model of the switched device as seen from its command pin
`default_nettype none
module hss_dev_model #(
   parameter int unsigned CLEAR_CYC = 40
) (
   input  wire logic clk,
   input  wire logic switch_cmd,
   input  wire logic over_temp,
   input  wire logic over_cur,
   input  wire logic gnd_lost,
   input  wire logic offstate_cond,
   output logic      sense_fault_pin,
   output logic      stage_on
);
   timeunit 1ns;
   timeprecision 1ns;
   // Starts asleep, as after power-up
   int unsigned low_cnt = CLEAR_CYC;
   logic        latched = 1'b0;
   logic        need_reset = 1'b0;
   logic        asleep;
   assign asleep = (low_cnt >= CLEAR_CYC);
   assign stage_on = switch_cmd && !latched && !gnd_lost && !need_reset;
   // Pull-down on the sense pin reads as no fault when it floats
   assign sense_fault_pin = latched || (asleep && offstate_cond);
   always @(posedge clk) begin
      low_cnt <= switch_cmd ? 0 : (asleep ? low_cnt : low_cnt + 1);
      if (stage_on && (over_temp || over_cur)) begin
         latched <= 1'b1;
      end else if (asleep) begin
         latched <= 1'b0;
      end
      if (gnd_lost) begin
         need_reset <= 1'b1;
      end else if (asleep) begin
         need_reset <= 1'b0;
      end
   end
endmodule // hss_dev_model
`default_nettype wire

// File: verification/high_side_switch_fault_latch_tb.sv
// Self-checking bench for the high-side switch controller
`default_nettype none
module high_side_switch_fault_latch_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import hss_pkg::*;
   // Clear time must exceed the sense settle time
   localparam int CLR = 3000;
   localparam int WK = 10;
   localparam int ON_CYC = SENSE_SETTLE_CYC + WK;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic user_on = 1'b0;
   logic gnd_reset_req = 1'b0;
   logic over_temp = 1'b0;
   logic over_cur = 1'b0;
   logic gnd_lost = 1'b0;
   logic offstate_cond = 1'b0;
   logic sense_fault_pin, switch_cmd, sense_valid, fault_latched, offstate_fault, ack_busy, stage_on;
   int   err_total = 0;
   int   comparisons = 0;

   hss_ctrl #(.CLEAR_CYC(CLR), .WAKE_CYC(WK)) i_dut (
      .clk(clk), .rst_n(rst_n), .user_on(user_on), .gnd_reset_req(gnd_reset_req),
      .sense_fault_pin(sense_fault_pin), .switch_cmd(switch_cmd), .sense_valid(sense_valid),
      .fault_latched(fault_latched), .offstate_fault(offstate_fault), .ack_busy(ack_busy));
   hss_dev_model #(.CLEAR_CYC(CLR)) i_dev (
      .clk(clk), .switch_cmd(switch_cmd), .over_temp(over_temp), .over_cur(over_cur),
      .gnd_lost(gnd_lost), .offstate_cond(offstate_cond), .sense_fault_pin(sense_fault_pin),
      .stage_on(stage_on));

   initial begin
      forever #10 clk = ~clk;
   end

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check_bit(input string what, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic check_range(input string what, input int lo, input int hi, input int got);
      comparisons++;
      if (got < lo || got > hi) begin
         err_total++;
         $display("unexpected %s: expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask

   localparam int SEL_VALID = 0;
   localparam int SEL_OFFST = 1;
   localparam int SEL_FAULT = 2;
   localparam int SEL_ACK   = 3;
   localparam int SEL_CMD   = 4;

   // Output chosen by index; re-read on every pass of the wait loop
   function automatic logic watched(input int sel);
      case (sel)
         SEL_VALID: return sense_valid;
         SEL_OFFST: return offstate_fault;
         SEL_FAULT: return fault_latched;
         SEL_ACK:   return ack_busy;
         default:   return switch_cmd;
      endcase
   endfunction

   // Bounded wait, counted in cycles
   task automatic wait_for(input int sel, input logic val, input int lim, output int n);
      n = 0;
      while (watched(sel) !== val && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic t_switch_on();
      int n;
      user_on = 1'b1;
      @(negedge clk);
      check_bit("switch_cmd on", 1'b1, switch_cmd);
      check_bit("sense_valid at turn-on", 1'b0, sense_valid);
      wait_for(SEL_VALID, 1'b1, ON_CYC + 10, n);
      check_range("sense settle", ON_CYC - 2, ON_CYC + 3, n);
      $display("test switch_on done");
   endtask

   // Off and straight back on: blanking first, then no wake delay as the device never slept
   task automatic t_quick_on();
      int n;
      user_on = 1'b0;
      @(negedge clk);
      check_bit("switch_cmd quick off", 1'b0, switch_cmd);
      user_on = 1'b1;
      wait_for(SEL_CMD, 1'b1, SENSE_SETTLE_CYC + 10, n);
      check_range("turn-off blanking", SENSE_SETTLE_CYC, SENSE_SETTLE_CYC + 4, n);
      check_bit("sense_valid at quick on", 1'b0, sense_valid);
      wait_for(SEL_VALID, 1'b1, ON_CYC + 10, n);
      check_range("settle awake", SENSE_SETTLE_CYC - 2, SENSE_SETTLE_CYC + 3, n);
      $display("test quick_on done");
   endtask

   task automatic t_off_sleep();
      int n;
      user_on = 1'b0;
      offstate_cond = 1'b1;
      @(negedge clk);
      check_bit("switch_cmd off", 1'b0, switch_cmd);
      check_bit("sense_valid off", 1'b0, sense_valid);
      wait_for(SEL_OFFST, 1'b1, CLR + 10, n);
      check_range("offstate delay", CLR - 2, CLR + 6, n);
      offstate_cond = 1'b0;
      repeat (4) @(negedge clk);
      $display("test off_sleep done");
   endtask

   task automatic t_fault(input bit temp);
      int n;
      over_temp = temp;
      over_cur = !temp;
      wait_for(SEL_FAULT, 1'b1, 6, n);
      check_bit("switch_cmd at fault", 1'b0, switch_cmd);
      check_bit("ack_busy at fault", 1'b1, ack_busy);
      check_bit("sense_valid at fault", 1'b0, sense_valid);
      over_temp = 1'b0;
      over_cur = 1'b0;
      user_on = 1'b0;
      wait_for(SEL_FAULT, 1'b0, CLR + 10, n);
      check_range("ack length", CLR - 1, CLR + 3, n);
      check_bit("sense pin after ack", 1'b0, sense_fault_pin);
      $display("test fault done");
   endtask

   task automatic t_gnd();
      int n;
      gnd_lost = 1'b1;
      repeat (2) @(negedge clk);
      check_bit("stage on ground loss", 1'b0, stage_on);
      gnd_lost = 1'b0;
      gnd_reset_req = 1'b1;
      @(negedge clk);
      gnd_reset_req = 1'b0;
      check_bit("ack_busy on reset", 1'b1, ack_busy);
      check_bit("switch_cmd on reset", 1'b0, switch_cmd);
      wait_for(SEL_ACK, 1'b0, CLR + 10, n);
      check_range("reset length", CLR - 1, CLR + 3, n);
      repeat (3) @(negedge clk);
      check_bit("stage after reset", 1'b1, stage_on);
      $display("test gnd done");
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      err_total++;
      close_out();
   end

   initial begin
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      t_switch_on();
      t_quick_on();
      t_off_sleep();
      t_switch_on();
      t_fault(1'b1);
      t_switch_on();
      t_fault(1'b0);
      t_switch_on();
      t_gnd();
      close_out();
   end
endmodule // high_side_switch_fault_latch_tb
`default_nettype wire
